// ===== pir_pkg.sv
// Package: register map, field positions, reset values and carriers
package pir_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] OFS_REQ_ONE  = 12'h000;
   localparam logic [11:0] OFS_REQ_TWO  = 12'h004;
   localparam logic [11:0] OFS_MASK_ONE = 12'h008;
   localparam logic [11:0] OFS_MASK_TWO = 12'h00C;
   localparam logic [11:0] OFS_ZC_CFG   = 12'h010;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int OSC_FAILSAFE_BIT = 7;
   localparam int CLOCK_SWITCH_BIT = 6;
   localparam int CONVERTER_BIT    = 0;
   localparam int ZERO_CROSS_BIT   = 6;
   localparam int COMP_TWO_BIT     = 1;
   localparam int COMP_ONE_BIT     = 0;
   localparam int ZC_RISE_BIT      = 0;
   localparam int ZC_FALL_BIT      = 1;

   // ---------------------------------------------------------------
   // Implemented bits and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] REQ_ONE_IMPL       = 8'hC1;
   localparam logic [7:0] REQ_TWO_IMPL_LARGE = 8'h43;
   localparam logic [7:0] REQ_TWO_IMPL_SMALL = 8'h41;
   localparam logic [7:0] REQ_RESET          = 8'h00;
   localparam logic [7:0] MASK_RESET         = 8'h00;
   localparam logic [1:0] ZC_CFG_RESET       = 2'h3;

   // Register selector
   typedef enum logic [2:0] {
      SEL_NONE, SEL_REQ_ONE, SEL_REQ_TWO, SEL_MASK_ONE, SEL_MASK_TWO, SEL_ZC_CFG
   } reg_sel_e;

   // Event inputs from the peripherals
   typedef struct packed {
      logic oscFail;
      logic clockSwitchReady;
      logic converterDone;
      logic zeroCrossOut;
      logic compOneIrq;
      logic compTwoIrq;
   } periph_evt_s;

   // APB request seen by the slave
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   // Decoded register write
   typedef struct packed {
      logic       wr;
      reg_sel_e   sel;
      logic [7:0] wdata;
   } reg_wr_s;

   // Readable register values
   typedef struct packed {
      logic [7:0] reqOne;
      logic [7:0] reqTwo;
      logic [7:0] maskOne;
      logic [7:0] maskTwo;
      logic [1:0] zcCfg;
   } reg_view_s;

   // Address decode
   function automatic reg_sel_e decodeAddr(input logic [11:0] addr);
      reg_sel_e s;
      if (addr == OFS_REQ_ONE) begin
         s = SEL_REQ_ONE;
      end else if (addr == OFS_REQ_TWO) begin
         s = SEL_REQ_TWO;
      end else if (addr == OFS_MASK_ONE) begin
         s = SEL_MASK_ONE;
      end else if (addr == OFS_MASK_TWO) begin
         s = SEL_MASK_TWO;
      end else if (addr == OFS_ZC_CFG) begin
         s = SEL_ZC_CFG;
      end else begin
         s = SEL_NONE;
      end
      return s;
   endfunction

endpackage

// ===== sticky_flag_bank.sv
// Module: eight sticky request flags, hardware set, write-one-to-clear
module sticky_flag_bank #(
   parameter logic [7:0] IMPL = 8'hFF
) (
   input  wire logic       clk,      // System clock
   input  wire logic       resetn,   // Async reset, active low
   input  wire logic [7:0] setEvt,   // Hardware set pulses
   input  wire logic       clrWr,    // Software clear write strobe
   input  wire logic [7:0] clrData,  // Ones clear the flag
   output logic      [7:0] flags     // Sticky flags
);

   typedef struct packed {
      logic [7:0] flags;
   } bank_state_s;

   bank_state_s stateQ;
   bank_state_s stateD;
   logic [7:0]  nextBit;

   // ---------------------------------------------------------------
   // Per-bit next value
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         // Set wins over clear; absent bits stay zero
         assign nextBit[i] = IMPL[i] & (setEvt[i] |                // [R9] [R12]
                             (stateQ.flags[i] & ~(clrWr & clrData[i])));  // [R8]
      end
   endgenerate

   // Next state
   always_comb begin
      stateD       = stateQ;
      stateD.flags = nextBit;
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stateQ.flags <= pir_pkg::REQ_RESET;                     // [R11]
      end else begin
         stateQ <= stateD;
      end
   end

   assign flags = stateQ.flags;

   property p_setWins;
      @(posedge clk) disable iff (!resetn)
      (setEvt != 8'h00) |=> ((flags & ($past(setEvt) & IMPL)) == ($past(setEvt) & IMPL));
   endproperty
   a_setWins: assert property (p_setWins) else $error("set event lost");  // [R12]

endmodule

// ===== apb_reg_slave.sv
// Module: APB slave front end with registered read data
module apb_reg_slave (
   input  wire logic              clk,      // System clock
   input  wire logic              resetn,   // Async reset, active low
   input  wire pir_pkg::apb_req_s req,      // APB request
   input  wire pir_pkg::reg_view_s view,    // Register values
   output logic [31:0]            prdata,   // Read data
   output logic                   pready,   // Transfer ready
   output logic                   pslverr,  // Unmapped address
   output pir_pkg::reg_wr_s       wrOut     // Decoded write
);

   typedef struct packed {
      logic [31:0] rdata;
   } slave_state_s;

   slave_state_s      stateQ;
   slave_state_s      stateD;
   pir_pkg::reg_sel_e sel;
   logic [7:0]        rdByte;
   logic              access;

   // Decode and access phase
   assign sel    = pir_pkg::decodeAddr(req.paddr);
   assign access = req.psel & req.penable;
   assign pready = access;
   assign pslverr = access & (sel == pir_pkg::SEL_NONE);

   // Read mux, unimplemented bits read zero
   always_comb begin
      rdByte = 8'h00;
      case (sel)
         pir_pkg::SEL_REQ_ONE:  rdByte = view.reqOne;
         pir_pkg::SEL_REQ_TWO:  rdByte = view.reqTwo;
         pir_pkg::SEL_MASK_ONE: rdByte = view.maskOne;
         pir_pkg::SEL_MASK_TWO: rdByte = view.maskTwo;
         pir_pkg::SEL_ZC_CFG:   rdByte = {6'h00, view.zcCfg};
         default:               rdByte = 8'h00;
      endcase
   end

   // Capture read data in the setup cycle
   always_comb begin
      stateD = stateQ;
      if (req.psel && !req.penable && !req.pwrite) begin
         stateD.rdata = {24'h00_0000, rdByte};
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stateQ.rdata <= 32'h0000_0000;
      end else begin
         stateQ <= stateD;
      end
   end

   assign prdata      = stateQ.rdata;
   assign wrOut.wr    = access & req.pwrite & (sel != pir_pkg::SEL_NONE);
   assign wrOut.sel   = sel;
   assign wrOut.wdata = req.pwdata[7:0];

endmodule

// ===== periph_irq_request_flags.sv
// Module: two peripheral interrupt request flag registers with mask and irq

// Operation
// R1: The oscillator fail-safe flag, bit 7 of request one, sets on a fail event and stays set.
// R2: The clock switch flag, bit 6 of request one, sets when the switch is ready and stays set.
// R3: The converter flag, bit 0 of request one, sets on completion and stays until cleared.
// R4: The zero-cross flag, bit 6 of request two, sets on each enabled edge and stays set.
// R5: The second comparator flag, bit 1 of request two, sets on its interrupt and stays set.
// R6: The first comparator flag, bit 0 of request two, sets on its interrupt and stays set.
// R7: The second comparator flag exists only on the larger variant, else it is absent.
// R8: Absent bits of both request registers read zero and ignore writes.
// R9: Each flag sets on its event whatever its enable bit and the global enable.
// R10: Software should clear a flag before it enables that source.
// R11: Every reset clears all request flags to zero.
// R12: A hardware set in the same cycle as a software clear wins.
module periph_irq_request_flags #(
   parameter bit LARGE_VARIANT = 1'b1  // Second comparator present
) (
   input  wire logic                 clk,          // System clock
   input  wire logic                 resetn,       // Async reset, active low
   input  wire logic                 psel,         // APB select
   input  wire logic                 penable,      // APB enable
   input  wire logic                 pwrite,       // APB direction
   input  wire logic [11:0]          paddr,        // APB byte address
   input  wire logic [31:0]          pwdata,       // APB write data
   output logic      [31:0]          prdata,       // APB read data
   output logic                      pready,       // APB ready
   output logic                      pslverr,      // APB error
   input  wire pir_pkg::periph_evt_s events,       // Peripheral events
   output logic      [7:0]           reqOneFlags,  // Request one flags
   output logic      [7:0]           reqTwoFlags,  // Request two flags
   output logic                      irq           // Masked interrupt level
);

   // ---------------------------------------------------------------
   // Constants
   // ---------------------------------------------------------------
   localparam logic [7:0] REQ_TWO_IMPL = LARGE_VARIANT ? pir_pkg::REQ_TWO_IMPL_LARGE
                                                        : pir_pkg::REQ_TWO_IMPL_SMALL;

   // ---------------------------------------------------------------
   // State and wires
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] maskOne;
      logic [7:0] maskTwo;
      logic [1:0] zcCfg;
      logic       zcPrev;
   } top_state_s;

   top_state_s         stateQ;
   top_state_s         stateD;
   pir_pkg::apb_req_s  busReq;
   pir_pkg::reg_wr_s   busWr;
   pir_pkg::reg_view_s view;
   logic [7:0]         setOne;
   logic [7:0]         setTwo;
   logic               clrOneWr;
   logic               clrTwoWr;
   logic               zcRise;
   logic               zcFall;
   logic               zcEvent;

   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------
   // Bundle the APB request
   assign busReq.psel    = psel;
   assign busReq.penable = penable;
   assign busReq.pwrite  = pwrite;
   assign busReq.paddr   = paddr;
   assign busReq.pwdata  = pwdata;

   // Readable registers
   assign view.reqOne  = reqOneFlags;
   assign view.reqTwo  = reqTwoFlags;
   assign view.maskOne = stateQ.maskOne;
   assign view.maskTwo = stateQ.maskTwo;
   assign view.zcCfg   = stateQ.zcCfg;

   apb_reg_slave u_slave (
      .clk     (clk),
      .resetn  (resetn),
      .req     (busReq),
      .view    (view),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .wrOut   (busWr)
   );

   // ---------------------------------------------------------------
   // Event capture
   // ---------------------------------------------------------------
   // Zero-cross edges qualified by their enables
   assign zcRise  = events.zeroCrossOut & ~stateQ.zcPrev;
   assign zcFall  = ~events.zeroCrossOut & stateQ.zcPrev;
   assign zcEvent = (zcRise & stateQ.zcCfg[pir_pkg::ZC_RISE_BIT]) |   // [R4]
                    (zcFall & stateQ.zcCfg[pir_pkg::ZC_FALL_BIT]);

   // Set vectors, independent of the masks; zero-cross uses its edge enables
   always_comb begin
      setOne = 8'h00;
      setTwo = 8'h00;
      setOne[pir_pkg::OSC_FAILSAFE_BIT] = events.oscFail;            // [R1] [R9]
      setOne[pir_pkg::CLOCK_SWITCH_BIT] = events.clockSwitchReady;   // [R2]
      setOne[pir_pkg::CONVERTER_BIT]    = events.converterDone;      // [R3]
      setTwo[pir_pkg::ZERO_CROSS_BIT]   = zcEvent;                   // [R4]
      setTwo[pir_pkg::COMP_TWO_BIT]     = events.compTwoIrq;         // [R5]
      setTwo[pir_pkg::COMP_ONE_BIT]     = events.compOneIrq;         // [R6]
   end

   // Write-one-to-clear strobes
   assign clrOneWr = busWr.wr & (busWr.sel == pir_pkg::SEL_REQ_ONE);
   assign clrTwoWr = busWr.wr & (busWr.sel == pir_pkg::SEL_REQ_TWO);

   // ---------------------------------------------------------------
   // Request flag banks
   // ---------------------------------------------------------------
   // Request one: fail-safe, clock switch, converter
   sticky_flag_bank #(
      .IMPL (pir_pkg::REQ_ONE_IMPL)                                  // [R8]
   ) u_req_one (
      .clk     (clk),
      .resetn  (resetn),
      .setEvt  (setOne),
      .clrWr   (clrOneWr),
      .clrData (busWr.wdata),
      .flags   (reqOneFlags)
   );

   // Request two: zero-cross and comparators
   sticky_flag_bank #(
      .IMPL (REQ_TWO_IMPL)                                           // [R7] [R8]
   ) u_req_two (
      .clk     (clk),
      .resetn  (resetn),
      .setEvt  (setTwo),
      .clrWr   (clrTwoWr),
      .clrData (busWr.wdata),
      .flags   (reqTwoFlags)
   );

   // ---------------------------------------------------------------
   // Mask, zero-cross config and edge history
   // ---------------------------------------------------------------
   // Masks keep only implemented bits
   always_comb begin
      stateD        = stateQ;
      stateD.zcPrev = events.zeroCrossOut;
      if (busWr.wr) begin
         case (busWr.sel)
            pir_pkg::SEL_MASK_ONE: stateD.maskOne = busWr.wdata & pir_pkg::REQ_ONE_IMPL;
            pir_pkg::SEL_MASK_TWO: stateD.maskTwo = busWr.wdata & REQ_TWO_IMPL;
            pir_pkg::SEL_ZC_CFG:   stateD.zcCfg   = busWr.wdata[1:0];
            default:               stateD.zcCfg   = stateQ.zcCfg;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stateQ.maskOne <= pir_pkg::MASK_RESET;
         stateQ.maskTwo <= pir_pkg::MASK_RESET;
         stateQ.zcCfg   <= pir_pkg::ZC_CFG_RESET;
         stateQ.zcPrev  <= 1'b0;
      end else begin
         stateQ <= stateD;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt output
   // ---------------------------------------------------------------
   // High while any unmasked flag is set
   assign irq = |(reqOneFlags & stateQ.maskOne) | |(reqTwoFlags & stateQ.maskTwo);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Fail-safe flag sets and holds
   property p_oscSetHold;
      @(posedge clk) disable iff (!resetn)
      events.oscFail |=> reqOneFlags[pir_pkg::OSC_FAILSAFE_BIT] [*2]
         or ($past(events.oscFail) && clrOneWr);
   endproperty
   a_oscSetHold: assert property (p_oscSetHold) else $error("fail-safe flag");  // [R1]

   // Clock switch flag holds without a clear
   property p_cswHold;
      @(posedge clk) disable iff (!resetn)
      (reqOneFlags[pir_pkg::CLOCK_SWITCH_BIT]
         && !(clrOneWr && busWr.wdata[pir_pkg::CLOCK_SWITCH_BIT]))
      |=> reqOneFlags[pir_pkg::CLOCK_SWITCH_BIT];
   endproperty
   a_cswHold: assert property (p_cswHold) else $error("clock switch flag lost");  // [R2]

   // Converter flag clears on a one written without an event
   property p_convClear;
      @(posedge clk) disable iff (!resetn)
      (clrOneWr && busWr.wdata[pir_pkg::CONVERTER_BIT] && !events.converterDone)
      |=> !reqOneFlags[pir_pkg::CONVERTER_BIT];
   endproperty
   a_convClear: assert property (p_convClear) else $error("converter clear");  // [R3]

   // Enabled rising edge of zero-cross output sets its flag
   property p_zcRise;
      @(posedge clk) disable iff (!resetn)
      ($rose(events.zeroCrossOut) && stateQ.zcCfg[pir_pkg::ZC_RISE_BIT])
      |=> reqTwoFlags[pir_pkg::ZERO_CROSS_BIT];
   endproperty
   a_zcRise: assert property (p_zcRise) else $error("zero-cross rise");  // [R4]

   // Edge with both enables off leaves a clear flag clear
   property p_zcMasked;
      @(posedge clk) disable iff (!resetn)
      (stateQ.zcCfg == 2'h0 && !reqTwoFlags[pir_pkg::ZERO_CROSS_BIT])
      |=> !reqTwoFlags[pir_pkg::ZERO_CROSS_BIT];
   endproperty
   a_zcMasked: assert property (p_zcMasked) else $error("zero-cross unexpected");  // [R4]

   // Second comparator flag sets on the larger variant
   property p_compTwo;
      @(posedge clk) disable iff (!resetn)
      (LARGE_VARIANT && events.compTwoIrq) |=> reqTwoFlags[pir_pkg::COMP_TWO_BIT];
   endproperty
   a_compTwo: assert property (p_compTwo) else $error("comparator two flag");  // [R5]

   // First comparator flag is still set two cycles after its event when no clear follows it
   property p_compOne;
      @(posedge clk) disable iff (!resetn)
      (events.compOneIrq ##1 !clrTwoWr) |=> reqTwoFlags[pir_pkg::COMP_ONE_BIT];
   endproperty
   a_compOne: assert property (p_compOne) else $error("comparator one flag");  // [R6]

   // Small variant never shows the second comparator flag
   property p_compTwoAbsent;
      @(posedge clk) disable iff (!resetn)
      !LARGE_VARIANT |-> !reqTwoFlags[pir_pkg::COMP_TWO_BIT];
   endproperty
   a_compTwoAbsent: assert property (p_compTwoAbsent) else $error("absent bit set");  // [R7]

   // Absent bits read zero in both registers
   property p_absentZero;
      @(posedge clk) disable iff (!resetn)
      ((reqOneFlags & ~pir_pkg::REQ_ONE_IMPL) == 8'h00)
      && ((reqTwoFlags & ~REQ_TWO_IMPL) == 8'h00);
   endproperty
   a_absentZero: assert property (p_absentZero) else $error("absent bit nonzero");  // [R8]

   // Converter flag sets even with mask one at zero, irq stays low
   property p_setIgnoresMask;
      @(posedge clk) disable iff (!resetn)
      (events.converterDone && stateQ.maskOne == 8'h00 && !busWr.wr)
      |=> (reqOneFlags[pir_pkg::CONVERTER_BIT] && !irq);
   endproperty
   a_setIgnoresMask: assert property (p_setIgnoresMask) else $error("mask blocked set");  // [R9]

   // All flags clear right after reset release
   property p_resetClear;
      @(posedge clk) disable iff (!resetn)
      $rose(resetn) |-> (reqOneFlags == 8'h00 && reqTwoFlags == 8'h00);
   endproperty
   a_resetClear: assert property (p_resetClear) else $error("flags not cleared");  // [R11]

   // Set beats a simultaneous clear
   property p_setBeatsClear;
      @(posedge clk) disable iff (!resetn)
      (events.oscFail && clrOneWr && busWr.wdata[pir_pkg::OSC_FAILSAFE_BIT])
      |=> reqOneFlags[pir_pkg::OSC_FAILSAFE_BIT];
   endproperty
   a_setBeatsClear: assert property (p_setBeatsClear) else $error("clear beat set");  // [R12]

   // Clock switch event sets its flag one cycle later
   property p_cswSet;
      @(posedge clk) disable iff (!resetn)
      events.clockSwitchReady |=> reqOneFlags[pir_pkg::CLOCK_SWITCH_BIT];
   endproperty
   a_cswSet: assert property (p_cswSet) else $error("clock switch flag not set");  // [R2]

   // Converter event sets its flag one cycle later
   property p_convSet;
      @(posedge clk) disable iff (!resetn)
      events.converterDone |=> reqOneFlags[pir_pkg::CONVERTER_BIT];
   endproperty
   a_convSet: assert property (p_convSet) else $error("converter flag not set");  // [R3]

   // Enabled falling edge of zero-cross output sets its flag
   property p_zcFall;
      @(posedge clk) disable iff (!resetn)
      ($fell(events.zeroCrossOut) && stateQ.zcCfg[pir_pkg::ZC_FALL_BIT])
      |=> reqTwoFlags[pir_pkg::ZERO_CROSS_BIT];
   endproperty
   a_zcFall: assert property (p_zcFall) else $error("zero-cross fall");  // [R4]

   // First comparator flag holds without a clear write
   property p_compOneHold;
      @(posedge clk) disable iff (!resetn)
      (reqTwoFlags[pir_pkg::COMP_ONE_BIT] && !clrTwoWr)
      |=> reqTwoFlags[pir_pkg::COMP_ONE_BIT];
   endproperty
   a_compOneHold: assert property (p_compOneHold) else $error("comparator one lost");  // [R6]

   // Unmasked converter flag raises the interrupt
   property p_irqFollows;
      @(posedge clk) disable iff (!resetn)
      (reqOneFlags[pir_pkg::CONVERTER_BIT] && stateQ.maskOne[pir_pkg::CONVERTER_BIT])
      |-> irq;
   endproperty
   a_irqFollows: assert property (p_irqFollows) else $error("irq missing");  // [R9]

   // Masks are clear right after reset release
   property p_maskReset;
      @(posedge clk) disable iff (!resetn)
      $rose(resetn) |-> (stateQ.maskOne == 8'h00 && stateQ.maskTwo == 8'h00 && !irq);
   endproperty
   a_maskReset: assert property (p_maskReset) else $error("mask not cleared");  // [R11]

endmodule

// ===== periph_event_source.sv
// Model of the peripheral event sources that feed the request flags
module periph_event_source (
   input  wire logic                 clk,     // System clock
   input  wire logic                 resetn,  // Async reset, active low
   input  wire logic [5:0]           fire,    // Event commands, struct order
   output pir_pkg::periph_evt_s      events   // Events to the flag block
);
   timeunit 1ns;
   timeprecision 1ps;

   logic zcLevel_q;

   // -------------------------------------------------------------
   // Zero-cross output level
   // -------------------------------------------------------------
   // Comparator level toggles on command, so rising and falling alternate
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         zcLevel_q <= 1'b0;
      end else if (fire[2]) begin
         zcLevel_q <= ~zcLevel_q;
      end
   end

   // Other sources pulse for exactly the commanded cycles
   always_comb begin
      events              = pir_pkg::periph_evt_s'(fire);
      events.zeroCrossOut = zcLevel_q;
   end
endmodule

// ===== periph_irq_request_flags_test.sv
// Testbench for the peripheral interrupt request flag block
module periph_irq_request_flags_test;
   timeunit 1ns;
   timeprecision 1ps;

   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   typedef struct {logic [5:0] f; logic [7:0] one; logic [7:0] two;} row_s;
   logic                 clk, resetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [11:0]          paddr, a, m;
   logic [31:0]          pwdata, prdata, rd;
   logic [7:0]           reqOneFlags, reqTwoFlags, twoSmall, e;
   logic [5:0]           fire;
   pir_pkg::periph_evt_s events;
   int                   n_mismatch, n_compared, cycles;
   row_s                 rows [6];

   // Main device, large variant
   periph_irq_request_flags dut_u (.clk(clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .events(events), .reqOneFlags(reqOneFlags),
      .reqTwoFlags(reqTwoFlags), .irq(irq));
   // Small variant on the same bus and events
   periph_irq_request_flags #(.LARGE_VARIANT(1'b0)) dut_small (.clk(clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(), .pready(), .pslverr(), .events(events), .reqOneFlags(),
      .reqTwoFlags(twoSmall), .irq());
   periph_event_source src_u (.clk(clk), .resetn(resetn), .fire(fire), .events(events));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; f drives events during the access phase
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
                      input logic [5:0] f, output logic [31:0] r, output logic er);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= ad;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      fire    <= f;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      er = pslverr;
      fire    <= 6'h00;
      psel    <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   task automatic pulse(input logic [5:0] f);
      @(posedge clk);
      fire <= f;
      @(posedge clk);
      fire <= 6'h00;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   // -------------------------------------------------------------
   // Sequence
   // -------------------------------------------------------------
   initial begin
      resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0000_0000; fire = 6'h00;
      rows = '{'{6'h20, 8'(1 << pir_pkg::OSC_FAILSAFE_BIT), 8'h00},
               '{6'h10, 8'(1 << pir_pkg::CLOCK_SWITCH_BIT), 8'h00},
               '{6'h08, 8'(1 << pir_pkg::CONVERTER_BIT), 8'h00},
               '{6'h04, 8'h00, 8'(1 << pir_pkg::ZERO_CROSS_BIT)},
               '{6'h02, 8'h00, 8'(1 << pir_pkg::COMP_ONE_BIT)},
               '{6'h01, 8'h00, 8'(1 << pir_pkg::COMP_TWO_BIT)}};
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      // Reset values of all five words
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0000_0000, 6'h00, rd, err);
         check("reset value", rd, (i == 4) ? 32'(pir_pkg::ZC_CFG_RESET) : 32'h0000_0000);
      end
      // Each source: set with masks off, unmask, clear
      foreach (rows[i]) begin
         a = (rows[i].one != 8'h00) ? pir_pkg::OFS_REQ_ONE : pir_pkg::OFS_REQ_TWO;
         m = (rows[i].one != 8'h00) ? pir_pkg::OFS_MASK_ONE : pir_pkg::OFS_MASK_TWO;
         e = rows[i].one | rows[i].two;
         pulse(rows[i].f);
         check("flags one", reqOneFlags, rows[i].one);
         check("flags two", reqTwoFlags, rows[i].two);
         check("irq masked", irq, 0);
         apb(1'b0, a, 32'h0000_0000, 6'h00, rd, err);
         check("read flag", rd, e);
         apb(1'b1, m, e, 6'h00, rd, err);
         check("irq unmasked", irq, 1);
         apb(1'b1, a, e, 6'h00, rd, err);
         check("flag cleared", reqOneFlags | reqTwoFlags, 0);
         check("irq cleared", irq, 0);
         apb(1'b1, m, 32'h0000_0000, 6'h00, rd, err);
      end
      // All events at once, zero-cross falling this time
      pulse(6'h3F);
      check("all one", reqOneFlags, pir_pkg::REQ_ONE_IMPL);
      check("all two", reqTwoFlags, pir_pkg::REQ_TWO_IMPL_LARGE);
      check("small two", twoSmall, pir_pkg::REQ_TWO_IMPL_SMALL);
      apb(1'b1, pir_pkg::OFS_REQ_ONE, 32'h0000_0000, 6'h00, rd, err);
      apb(1'b0, pir_pkg::OFS_REQ_ONE, 32'h0000_0000, 6'h00, rd, err);
      check("zero write", rd, 32'(pir_pkg::REQ_ONE_IMPL));
      apb(1'b1, pir_pkg::OFS_REQ_ONE, 32'h0000_00FF, 6'h00, rd, err);
      apb(1'b1, pir_pkg::OFS_REQ_TWO, 32'h0000_00FF, 6'h00, rd, err);
      apb(1'b0, pir_pkg::OFS_REQ_TWO, 32'h0000_0000, 6'h00, rd, err);
      check("two cleared", rd, 32'h0000_0000);
      check("small cleared", twoSmall, 8'h00);
      // Unmapped word
      apb(1'b1, 12'h020, 32'h0000_00FF, 6'h00, rd, err);
      check("unmapped write err", err, 1);
      apb(1'b0, 12'h020, 32'h0000_0000, 6'h00, rd, err);
      check("unmapped read", {rd[30:0], err}, 32'h0000_0001);
      // Events in the clearing cycle survive
      apb(1'b1, pir_pkg::OFS_REQ_ONE, 32'h0000_0081, 6'h28, rd, err);
      check("set over clear", reqOneFlags, 8'h81);
      // Reset in mid-run with irq high
      pulse(6'h22);
      apb(1'b1, pir_pkg::OFS_MASK_ONE, 32'h0000_00C1, 6'h00, rd, err);
      check("irq before reset", irq, 1);
      @(posedge clk);
      resetn <= 1'b0;
      #1;
      check("reset flags", {reqOneFlags, reqTwoFlags, 7'h00, irq}, 32'h0000_0000);
      @(posedge clk);
      resetn <= 1'b1;
      apb(1'b0, pir_pkg::OFS_MASK_ONE, 32'h0000_0000, 6'h00, rd, err);
      check("mask after reset", rd, 32'h0000_0000);
      check("flags after reset", {reqOneFlags, reqTwoFlags, 7'h00, irq}, 32'h0000_0000);
      print_verdict();
   end
endmodule
